// ===== shared/bwm_defs.svh
// Offsets, field positions and sizes for the bandwidth usage monitor id register.
// Included by the package and design files; definitions only.
`ifndef BWM_DEFS_SVH
`define BWM_DEFS_SVH
`define BWM_ID_OFFSET 12'h090
`define BWM_ADDR_W 12
`define BWM_DATA_W 32
`define BWM_CAPTURE_BIT 31
`define BWM_WIDE_BIT 30
`define BWM_WIDTH_SEL_BIT 29
`define BWM_RW_FILTER_BIT 28
`define BWM_OVERFLOW_BIT 26
`define BWM_SCALE_LSB 16
`define BWM_SCALE_W 5
`define BWM_COUNT_LSB 0
`define BWM_COUNT_W 16
`define BWM_INST_W 4
`define BWM_NUM_INST 1
`define BWM_SCALE_DEFAULT 5'h00
`define BWM_COUNT_DEFAULT 16'h0001
`endif

// ===== shared/bwm_pkg.sv
// Types for the bandwidth usage monitor id register block.
// Relies on bwm_defs.svh for the scale and count widths.
`include "bwm_defs.svh"
package bwm_pkg;
  // Capability record of one resource instance
  typedef struct packed {
    logic capture;
    logic wide;
    logic width_sel;
    logic rw_filter;
    logic overflow;
    logic [`BWM_SCALE_W-1:0] scale;
    logic [`BWM_COUNT_W-1:0] count;
  } bwm_caps_t;
  localparam int BWM_CAPS_W = 5 + `BWM_SCALE_W + `BWM_COUNT_W;
endpackage

// ===== src/bwm_caps_rom.sv
// Registered-read table of per-instance capability words.
// Assumes one clock, synchronous active-low reset, shared clock enable.
`timescale 1ns/1ps
`include "bwm_defs.svh"
module bwm_caps_rom
  import bwm_pkg::*;
#(
  parameter int NUM_INST = `BWM_NUM_INST,
  parameter int INST_W = `BWM_INST_W,
  parameter logic [NUM_INST*BWM_CAPS_W-1:0] TABLE = '0
)(
  input wire logic clock, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic clk_en, // Freezes state when low
  input wire logic [INST_W-1:0] inst, // Instance to look up
  output logic [BWM_CAPS_W-1:0] rdata // Registered capability word
);
  // Refuse a table that the select field cannot address
  if (INST_W < 1 || INST_W > 16 || NUM_INST < 1 || NUM_INST > (1 << INST_W))
  begin : g_bad_inst
    $error("NUM_INST does not fit INST_W");
  end

  typedef struct packed {
    logic [BWM_CAPS_W-1:0] data;
  } bwm_rom_state_t;
  bwm_rom_state_t state_reg;
  bwm_rom_state_t state_next;

  // Pick the entry; out-of-range instance reads zero
  always_comb
  begin
    state_next = state_reg;
    state_next.data = '0;
    for (int i = 0; i < NUM_INST; i++)
    begin
      if (inst == INST_W'(i))
        state_next.data = TABLE[i*BWM_CAPS_W +: BWM_CAPS_W];
    end
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (!resetn)
      state_reg <= '0;
    else if (clk_en)
      state_reg <= state_next;
  end
  assign rdata = state_reg.data;
endmodule // bwm_caps_rom

// ===== src/bwm_id_reg.sv
// Read-only id register that reports bandwidth usage monitor capabilities.
// Assumes a simple read/write register port from the feature page decoder,
// with Secure and Non-secure pages told apart by a page select input.
// Function
// [R1] Present only when all three features exist
// [R2] One 32-bit read-only word
// [R3] Bit 31 reports capture snapshot support
// [R4] Bit 30 reports wide counter presence
// [R5] Bit 29 selects 44 or 63 bit width
// [R6] Width select reads zero without wide counter
// [R7] Bit 28 reports read/write filter selection
// [R8] Bit 26 reports overflow bitmap presence
// [R9] Bits 30,29,28,26 zero on older revisions
// [R10] Bits 20:16 give usage counter shift
// [R11] Bits 15:0 give monitor instance count
// [R12] Instance fields follow partition-select instance
// [R13] Readable from Secure and Non-secure pages
// [R14] Separate copies when page contents differ
// [R15] Monitor-select instance field is ignored
// [R16] Reserved bits zero, writes ignored
`timescale 1ns/1ps
`include "bwm_defs.svh"
module bwm_id_reg
  import bwm_pkg::*;
#(
  parameter int NUM_INST = `BWM_NUM_INST,
  parameter int INST_W = `BWM_INST_W,
  parameter bit SPLIT_PAGES = 1'h0,
  parameter logic [NUM_INST*BWM_CAPS_W-1:0] SEC_TABLE =
    {5'h00, `BWM_SCALE_DEFAULT, `BWM_COUNT_DEFAULT},
  parameter logic [NUM_INST*BWM_CAPS_W-1:0] NSEC_TABLE = SEC_TABLE
)(
  input wire logic clock, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic clk_en, // Freezes state when low
  input wire logic partitioning_feature, // Partitioning feature present
  input wire logic monitoring_present, // Monitoring present
  input wire logic bw_monitoring_present, // Bandwidth usage monitoring present
  input wire logic late_revision, // Revision defines bits 30,29,28,26
  input wire logic instance_select_present, // Resource-instance selection exists
  input wire logic [INST_W-1:0] resource_instance_select, // Partition-select instance field
  input wire logic [INST_W-1:0] monitor_sel_instance, // Monitor-select instance, unused
  input wire logic secure_page, // Access comes through Secure page
  input wire logic rd_en, // Read strobe
  input wire logic wr_en, // Write strobe, ignored
  input wire logic [`BWM_ADDR_W-1:0] addr, // Byte offset in feature page
  input wire logic [`BWM_DATA_W-1:0] wdata, // Write data, ignored
  output logic [`BWM_DATA_W-1:0] rdata, // Registered read data
  output logic rvalid // Read data valid pulse
);
  // Refuse instance counts that the select field cannot reach
  if (INST_W < 1 || INST_W > 16 || NUM_INST < 1 || NUM_INST > (1 << INST_W))
  begin : g_bad_inst
    $error("NUM_INST does not fit INST_W");
  end

  typedef struct packed {
    logic [`BWM_DATA_W-1:0] rdata;
    logic rvalid;
    logic pend;
    logic pend_hit;
    logic page_sel;
    logic [`BWM_DATA_W-1:0] unused_sink;
  } bwm_state_t;
  bwm_state_t state_reg;
  bwm_state_t state_next;

  logic [BWM_CAPS_W-1:0] sec_caps;
  logic [BWM_CAPS_W-1:0] nsec_caps;
  logic [INST_W-1:0] inst_sel;
  bwm_caps_t caps;

  // Instance choice uses only the partition-select field
  assign inst_sel = instance_select_present ? resource_instance_select : '0; // see [R12] see [R15]

  // Pack capability word into register layout
  function automatic logic [`BWM_DATA_W-1:0] pack_id(bwm_caps_t c, logic late);
    logic [`BWM_DATA_W-1:0] w;
    w = '0; // see [R16]
    w[`BWM_CAPTURE_BIT] = c.capture; // see [R3]
    if (late) // see [R9]
    begin
      w[`BWM_WIDE_BIT] = c.wide; // see [R4]
      w[`BWM_WIDTH_SEL_BIT] = c.wide & c.width_sel; // see [R5] see [R6]
      w[`BWM_RW_FILTER_BIT] = c.rw_filter; // see [R7]
      w[`BWM_OVERFLOW_BIT] = c.overflow; // see [R8]
    end
    w[`BWM_SCALE_LSB +: `BWM_SCALE_W] = c.scale; // see [R10]
    w[`BWM_COUNT_LSB +: `BWM_COUNT_W] = c.count; // see [R11]
    return w;
  endfunction

  // Secure copy lookup
  bwm_caps_rom #(
    .NUM_INST(NUM_INST),
    .INST_W(INST_W),
    .TABLE(SEC_TABLE)
  ) u_sec_rom (
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .inst(inst_sel),
    .rdata(sec_caps)
  );

  // Separate Non-secure copy only when contents differ
  generate
    if (SPLIT_PAGES)
    begin : g_split
      bwm_caps_rom #(
        .NUM_INST(NUM_INST),
        .INST_W(INST_W),
        .TABLE(NSEC_TABLE)
      ) u_nsec_rom (
        .clock(clock),
        .resetn(resetn),
        .clk_en(clk_en),
        .inst(inst_sel),
        .rdata(nsec_caps)
      ); // see [R14]
    end
    else
    begin : g_shared
      assign nsec_caps = sec_caps; // see [R14]
    end
  endgenerate

  // Page of the pending read, captured with the table lookup
  assign caps = state_reg.page_sel ? bwm_caps_t'(sec_caps) : bwm_caps_t'(nsec_caps); // see [R13]

  // Read in two steps: decode, then format from table output
  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = 1'h0;
    state_next.pend = rd_en;
    state_next.page_sel = secure_page; // see [R13]
    state_next.pend_hit = (addr == `BWM_ID_OFFSET) && partitioning_feature
      && monitoring_present && bw_monitoring_present; // see [R1]
    state_next.unused_sink = wr_en ? wdata : state_reg.unused_sink; // see [R16]
    if (state_reg.pend)
    begin
      state_next.rvalid = 1'h1;
      state_next.rdata = state_reg.pend_hit ? pack_id(caps, late_revision) : '0; // see [R1] see [R2]
    end
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (!resetn)
      state_reg <= '0;
    else if (clk_en)
      state_reg <= state_next;
  end

  assign rdata = state_reg.rdata;
  assign rvalid = state_reg.rvalid;
endmodule // bwm_id_reg

// ===== verification/bwm_id_reg_properties.sv
// Checker for the read port of the bandwidth monitor id register.
// Bound to bwm_id_reg; sees its ports only; timing counts enabled cycles.
`timescale 1ns/1ps
module bwm_id_props (
  input wire logic clock, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic clk_en, // Enable
  input wire logic partitioning_feature, // Feature
  input wire logic monitoring_present, // Feature
  input wire logic bw_monitoring_present, // Feature
  input wire logic late_revision, // Revision
  input wire logic rd_en, // Read strobe
  input wire logic [11:0] addr, // Offset
  input wire logic [31:0] rdata, // Read data
  input wire logic rvalid // Read valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Answer timing, counted in enabled cycles only
  a_read_latency: assert property (rd_en && clk_en ##1 clk_en |=> rvalid) else $error("no answer");
  a_no_spurious: assert property (rvalid && $past(clk_en) && $past(clk_en, 2) |-> $past(rd_en, 2))
    else $error("stray answer");
  a_rdata_holds: assert property (!rvalid |-> $stable(rdata)) else $error("data moved");
  a_freeze_holds: assert property (!clk_en |=> $stable(rdata) && $stable(rvalid))
    else $error("not frozen");
  // Zero words and fields
  a_absent_zero: assert property (rd_en && clk_en && !(partitioning_feature && monitoring_present
    && bw_monitoring_present) ##1 clk_en |=> rdata == 32'h0) else $error("absent not zero");
  a_other_zero: assert property (rd_en && clk_en && addr != 12'h090 ##1 clk_en |=> rdata == 32'h0)
    else $error("bad offset");
  a_reserved_zero: assert property (rvalid |-> !rdata[27] && rdata[25:21] == 5'h00)
    else $error("reserved");
  a_width_needs_wide: assert property (rvalid |-> !(rdata[29] && !rdata[30])) else $error("width bit");
  a_old_rev_zero: assert property (rd_en && clk_en ##1 clk_en && !late_revision
    |=> rdata[30:28] == 3'h0 && !rdata[26]) else $error("old revision");
  // Main scenarios
  c_capture: cover property (rvalid && rdata[31]);
  c_wide: cover property (rvalid && rdata[30] && rdata[29]);
  c_burst: cover property (rd_en ##1 rd_en ##1 rd_en);
  c_freeze: cover property (rd_en && clk_en ##1 !clk_en);
endmodule // bwm_id_props
bind bwm_id_reg bwm_id_props u_props (
  .clock(clock),
  .resetn(resetn),
  .clk_en(clk_en),
  .partitioning_feature(partitioning_feature),
  .monitoring_present(monitoring_present),
  .bw_monitoring_present(bw_monitoring_present),
  .late_revision(late_revision),
  .rd_en(rd_en),
  .addr(addr),
  .rdata(rdata),
  .rvalid(rvalid)
);

// ===== verification/bwm_id_reg_tb.sv
// Self-checking bench for the bandwidth monitor id register.
// Drives ports at the falling edge; two instances, split pages.
`timescale 1ns/1ps
module bwm_id_reg_tb;
  import bwm_pkg::*;
  localparam logic [51:0] SEC = {5'h15, 5'h03, 16'h0004, 5'h1F, 5'h1F, 16'hABCD};
  localparam logic [51:0] NSEC = {5'h0A, 5'h00, 16'h0002, 5'h0C, 5'h0A, 16'h8001};
  logic clock, resetn, clk_en, partitioning_feature, monitoring_present, bw_monitoring_present;
  logic late_revision, instance_select_present, secure_page, rd_en, wr_en, rvalid;
  logic [3:0] resource_instance_select, monitor_sel_instance;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, rs;
  logic [31:0] q[$];
  int bad_count, tests_run;
  bwm_id_reg #(.NUM_INST(2), .SPLIT_PAGES(1'h1), .SEC_TABLE(SEC), .NSEC_TABLE(NSEC)) u_dut (
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .partitioning_feature(partitioning_feature),
    .monitoring_present(monitoring_present),
    .bw_monitoring_present(bw_monitoring_present),
    .late_revision(late_revision),
    .instance_select_present(instance_select_present),
    .resource_instance_select(resource_instance_select),
    .monitor_sel_instance(monitor_sel_instance),
    .secure_page(secure_page),
    .rd_en(rd_en),
    .wr_en(wr_en),
    .addr(addr),
    .wdata(wdata),
    .rdata(rdata),
    .rvalid(rvalid)
  );
  // Next value of the stimulus sequence
  function automatic logic [31:0] xorshift(logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Expected word from the tables
  function automatic logic [31:0] word(logic [3:0] i, logic l);
    logic [51:0] t;
    logic [25:0] e;
    t = secure_page ? SEC : NSEC;
    e = (instance_select_present && i[0]) ? t[51:26] : t[25:0];
    if (!(partitioning_feature && monitoring_present && bw_monitoring_present) || addr != 12'h090
        || (instance_select_present && i > 4'h1))
      return 32'h0;
    return {e[25], e[24] & l, e[23] & e[24] & l, e[22] & l, 1'b0, e[21] & l, 5'h00, e[20:0]};
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // Watchdog
  initial
  begin
    #20000;
    bad_count++;
    end_of_test();
  end
  // Checks each answer against the oldest note, at the falling edge once outputs settle
  always @(negedge clock)
    if (resetn === 1'h1 && rvalid === 1'h1)
    begin
      tests_run++;
      if (q.size() == 0 || rdata !== q[0])
      begin
        bad_count++;
        $display("BAD %0t rdata %h", $time, rdata);
      end
      if (q.size() > 0)
        void'(q.pop_front());
    end
  // Main sequence
  initial
  begin
    rs = 32'h0000004E;
    {resetn, rd_en, wr_en, secure_page, late_revision, instance_select_present} = '0;
    {partitioning_feature, monitoring_present, bw_monitoring_present, clk_en} = 4'hF;
    {resource_instance_select, monitor_sel_instance, addr, wdata} = '0;
    repeat (16) @(negedge clock);
    resetn = 1;
    tests_run++;
    if (rdata !== 32'h0 || rvalid !== 1'b0)
    begin
      bad_count++;
      $display("BAD %0t reset values", $time);
    end
    for (int l = 0; l < 2; l++)
    begin
      late_revision = l[0];
      for (int k = 0; k < 70; k++)
      begin
        @(negedge clock);
        rs = xorshift(rs);
        rd_en = k < 66 && (rs[0] | rs[1]);
        secure_page = rs[2];
        resource_instance_select = rs[3] ? {3'h0, rs[4]} : rs[7:4];
        instance_select_present = rs[8] | rs[9];
        addr = (rs[10] & rs[11]) ? rs[23:12] : 12'h090;
        {partitioning_feature, monitoring_present, bw_monitoring_present} = (rs[12] & rs[13]) ? rs[26:24] : 3'h7;
        monitor_sel_instance = rs[30:27];
        wr_en = rs[31];
        wdata = rs;
        if (rd_en)
          q.push_back(word(resource_instance_select, l[0]));
      end
    end
    // Freeze a read in flight; take-time page and instance must survive
    @(negedge clock);
    {partitioning_feature, monitoring_present, bw_monitoring_present} = 3'h7;
    rd_en = 1'h1;
    addr = 12'h090;
    secure_page = 1'h1;
    instance_select_present = 1'h1;
    resource_instance_select = 4'h0;
    q.push_back(word(4'h0, 1'h1));
    @(negedge clock);
    clk_en = 1'h0;
    rd_en = 1'h0;
    secure_page = 1'h0;
    resource_instance_select = 4'h1;
    repeat (3) @(negedge clock);
    clk_en = 1'h1;
    repeat (3) @(negedge clock);
    // Reset in mid-run must clear the data left by the last answer
    resetn = 1'h0;
    repeat (2) @(negedge clock);
    tests_run++;
    if (rdata !== 32'h0 || rvalid !== 1'h0)
    begin
      bad_count++;
      $display("BAD %0t reset in mid-run", $time);
    end
    resetn = 1'h1;
    repeat (4) @(negedge clock);
    tests_run++;
    if (q.size() != 0)
    begin
      bad_count++;
      $display("BAD %0t missing answers", $time);
    end
    end_of_test();
  end
endmodule // bwm_id_reg_tb
